//--- design/pdc_divider.sv
`timescale 1ns/10ps
module pdc_divider #(parameter int W = 6) (
  input wire logic clock,
  input wire logic nrst,
  pdc_div_if.div dv
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic pulse_ff;
  logic nxt_pulse;
  logic level_ff;
  logic nxt_level;
  logic wrap;

  // Ratio 0 wraps at all ones, so it divides by two to the W
  assign wrap = (cnt_ff >= W'(dv.ratio - 1'b1));

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_pulse = 1'b0;
    nxt_level = level_ff;
    if (dv.clear) begin
      nxt_cnt = '0;
      nxt_level = 1'b0;
    end else if (dv.tick) begin
      if (wrap) begin
        nxt_cnt = '0;
        nxt_pulse = 1'b1;
        nxt_level = ~level_ff;
      end else begin
        nxt_cnt = W'(cnt_ff + 1'b1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_ff <= '0;
      pulse_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
      level_ff <= nxt_level;
    end
  end

  assign dv.pulse = pulse_ff;
  assign dv.level = level_ff;
endmodule : pdc_divider

//--- design/pdc_top.sv
`timescale 1ns/10ps
// What this block does
// - Reference output runs when its enable bit is set and PLL is on.
// - Reference output enable comes out of reset set.
// - Post divider codes 0,1,2 divide by 1,2,4; output is sampling clock.
// - Prescale codes 0,1,2 divide by 5,4,3; output feeds post divider.
// - Loop divider divides sampling clock by its value, 1 to 63.
// - Loop divider resets to divide by thirty-two.
// - One pre-emphasis setting drives all eight lanes.
// - Auxiliary enable bit turns auxiliary buffer and divider on or off.
// - Aux modes 0,1,2 give 16,32,64 UI clocks; 3 gives timestamp.
// - Aux clock modes follow serializer and break on its reinit.
// - Active pin override turns the PLL on from its value bit.
module pdc_top
  import pdc_pkg::*;
#(
  parameter int LANES = 8,
  parameter int PE_W = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic pll_enable_pin,
  input wire logic override_active,
  input wire logic override_pll_on_value,
  input wire logic synth_pll_reset,
  input wire logic sample_tick,
  input wire logic ui_tick,
  input wire logic ser_reinit,
  input wire logic timestamp_input,
  output logic pll_on,
  output logic synth_ref_output,
  output logic [2:0] prescale_ratio,
  output logic [2:0] post_ratio,
  output logic [5:0] loop_ratio,
  output logic feedback_tick,
  output logic [6:0] oscillator_bias,
  output logic [LANES*PE_W-1:0] lane_preemphasis,
  output logic aux_output_enable,
  output logic aux_clock_output
);
  pdc_spi_state_t st_ff, nxt_st;
  logic sclk_ff, nxt_sclk;
  logic [4:0] bit_ff, nxt_bit;
  logic [15:0] head_ff, nxt_head;
  logic [7:0] din_ff, nxt_din;
  logic [7:0] dout_ff, nxt_dout;
  logic sdo_ff, nxt_sdo;
  logic oe_ff, nxt_oe;
  logic rise, fall;
  logic [14:0] adr;
  logic [7:0] rd_data;
  logic wr_en;

  logic [7:0] ref_ctrl_ff, nxt_ref_ctrl;
  logic [7:0] fbdiv1_ff, nxt_fbdiv1;
  logic [7:0] fbdiv2_ff, nxt_fbdiv2;
  logic [7:0] bias_ff, nxt_bias;
  logic [7:0] pe_ff, nxt_pe;
  logic [7:0] aux_ctrl_ff, nxt_aux_ctrl;

  logic rst_hold_ff, nxt_rst_hold;
  logic [2:0] pre_ff, nxt_pre;
  logic [2:0] post_ff, nxt_post;
  logic [5:0] loop_ff, nxt_loop;
  logic ref_out_ff, nxt_ref_out;
  logic [LANES*PE_W-1:0] lanes_ff, nxt_lanes;
  logic ts_ff, nxt_ts;
  logic aux_out_ff, nxt_aux_out;
  logic [2:0] aux_mode;
  logic aux_en;
  logic aux_clk_mode;

  pdc_div_if #(.W(6)) loop_if ();
  pdc_div_if #(.W(6)) aux_if ();

  assign rise = spi_sclk & ~sclk_ff;
  assign fall = ~spi_sclk & sclk_ff;
  assign adr = head_ff[SPI_RW_BIT-1:0];

  // Serial control port; a frame aborted by chip select high is dropped
  always_comb begin
    nxt_st = st_ff;
    nxt_sclk = spi_sclk;
    nxt_bit = bit_ff;
    nxt_head = head_ff;
    nxt_din = din_ff;
    nxt_dout = dout_ff;
    nxt_sdo = sdo_ff;
    nxt_oe = oe_ff;
    wr_en = 1'b0;
    if (spi_csb_n) begin
      nxt_st = ST_IDLE;
      nxt_bit = '0;
      nxt_oe = 1'b0;
      nxt_sdo = 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_st = ST_HEAD;
          nxt_bit = '0;
        end
        ST_HEAD: begin
          if (rise) begin
            nxt_head = {head_ff[14:0], spi_sdi};
            nxt_bit = 5'(bit_ff + 1'b1);
            if (nxt_bit == SPI_HEAD_BITS) begin
              nxt_st = ST_DATA;
              nxt_dout = rd_data;
              nxt_oe = head_ff[SPI_RW_BIT-1];
            end
          end
        end
        ST_DATA: begin
          if (fall && oe_ff) begin
            nxt_sdo = dout_ff[7];
            nxt_dout = {dout_ff[6:0], 1'b0};
          end
          if (rise) begin
            nxt_din = {din_ff[6:0], spi_sdi};
            nxt_bit = 5'(bit_ff + 1'b1);
            if (nxt_bit == SPI_FRAME_BITS) begin
              nxt_st = ST_DONE;
              wr_en = ~head_ff[SPI_RW_BIT];
            end
          end
        end
        ST_DONE: begin
          nxt_st = ST_DONE;
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end

  // The address is completed here with the live sdi bit, on the edge that shifts it into head_ff
  always_comb begin
    logic [14:0] a;
    a = {head_ff[13:0], spi_sdi};
    if (a == ADR_REF_CTRL) begin
      rd_data = ref_ctrl_ff;
    end else if (a == ADR_FBDIV1) begin
      rd_data = fbdiv1_ff;
    end else if (a == ADR_FBDIV2) begin
      rd_data = fbdiv2_ff;
    end else if (a == ADR_BIAS) begin
      rd_data = bias_ff;
    end else if (a == ADR_PE) begin
      rd_data = pe_ff;
    end else if (a == ADR_AUX) begin
      rd_data = aux_ctrl_ff;
    end else begin
      rd_data = RD_UNMAPPED;
    end
  end

  // Reserved bits are stored as written and read back unchanged
  always_comb begin
    logic [7:0] d;
    d = {din_ff[6:0], spi_sdi};
    nxt_ref_ctrl = ref_ctrl_ff;
    nxt_fbdiv1 = fbdiv1_ff;
    nxt_fbdiv2 = fbdiv2_ff;
    nxt_bias = bias_ff;
    nxt_pe = pe_ff;
    nxt_aux_ctrl = aux_ctrl_ff;
    if (wr_en) begin
      if (adr == ADR_REF_CTRL) begin
        nxt_ref_ctrl = d;
      end else if (adr == ADR_FBDIV1) begin
        nxt_fbdiv1 = d;
      end else if (adr == ADR_FBDIV2) begin
        nxt_fbdiv2 = d;
      end else if (adr == ADR_BIAS) begin
        nxt_bias = d;
      end else if (adr == ADR_PE) begin
        nxt_pe = d;
      end else if (adr == ADR_AUX) begin
        nxt_aux_ctrl = d;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      sclk_ff <= 1'b0;
      bit_ff <= '0;
      head_ff <= '0;
      din_ff <= '0;
      dout_ff <= '0;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      ref_ctrl_ff <= RST_REF_CTRL;
      fbdiv1_ff <= RST_FBDIV1;
      fbdiv2_ff <= RST_FBDIV2;
      bias_ff <= RST_BIAS;
      pe_ff <= RST_PE;
      aux_ctrl_ff <= RST_AUX;
    end else begin
      st_ff <= nxt_st;
      sclk_ff <= nxt_sclk;
      bit_ff <= nxt_bit;
      head_ff <= nxt_head;
      din_ff <= nxt_din;
      dout_ff <= nxt_dout;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      ref_ctrl_ff <= nxt_ref_ctrl;
      fbdiv1_ff <= nxt_fbdiv1;
      fbdiv2_ff <= nxt_fbdiv2;
      bias_ff <= nxt_bias;
      pe_ff <= nxt_pe;
      aux_ctrl_ff <= nxt_aux_ctrl;
    end
  end

  assign pll_on = override_active ? override_pll_on_value
                                  : pll_enable_pin;
  assign aux_en = aux_ctrl_ff[AUX_EN_BIT];
  assign aux_mode = aux_ctrl_ff[AUX_MODE_HI:0];
  assign aux_clk_mode = (aux_mode <= MODE_UI64);

  // Ratios move only on release of PLL reset, so the loop never sees a
  // half-applied setting while software rewrites the fields
  always_comb begin
    nxt_rst_hold = synth_pll_reset;
    nxt_pre = pre_ff;
    nxt_post = post_ff;
    nxt_loop = loop_ff;
    if (rst_hold_ff && !synth_pll_reset) begin
      nxt_pre = pdc_pre_ratio(fbdiv1_ff[PRE_HI:PRE_LO]);
      nxt_post = pdc_post_ratio(fbdiv1_ff[POST_HI:POST_LO]);
      nxt_loop = fbdiv2_ff[LOOP_HI:0];
    end
    nxt_ref_out = ref_ctrl_ff[REF_EN_BIT] & pll_on;
    nxt_lanes = {LANES{pe_ff[PE_HI:0]}};
    nxt_ts = timestamp_input;
    nxt_aux_out = 1'b0;
    if (aux_en) begin
      if (aux_clk_mode) begin
        nxt_aux_out = aux_if.level;
      end else if (aux_mode == MODE_TSTAMP) begin
        nxt_aux_out = ts_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rst_hold_ff <= 1'b0;
      pre_ff <= RATIO_5;
      post_ff <= RATIO_1;
      loop_ff <= RST_FBDIV2[LOOP_HI:0];
      ref_out_ff <= 1'b0;
      lanes_ff <= '0;
      ts_ff <= 1'b0;
      aux_out_ff <= 1'b0;
    end else begin
      rst_hold_ff <= nxt_rst_hold;
      pre_ff <= nxt_pre;
      post_ff <= nxt_post;
      loop_ff <= nxt_loop;
      ref_out_ff <= nxt_ref_out;
      lanes_ff <= nxt_lanes;
      ts_ff <= nxt_ts;
      aux_out_ff <= nxt_aux_out;
    end
  end

  assign loop_if.clear = synth_pll_reset | ~pll_on;
  assign loop_if.tick = sample_tick;
  assign loop_if.ratio = loop_ff;
  // Mode is sampled live; changing it while enabled would glitch
  assign aux_if.clear = ~aux_en | ser_reinit | ~aux_clk_mode;
  assign aux_if.tick = ui_tick;
  assign aux_if.ratio = pdc_aux_half(aux_mode);

  pdc_divider #(.W(6)) u_loop_div (.clock(clock), .nrst(nrst),
    .dv(loop_if.div));
  pdc_divider #(.W(6)) u_aux_div (.clock(clock), .nrst(nrst),
    .dv(aux_if.div));

  assign spi_sdo = sdo_ff;
  assign spi_sdo_oe = oe_ff;
  assign synth_ref_output = ref_out_ff;
  assign prescale_ratio = pre_ff;
  assign post_ratio = post_ff;
  assign loop_ratio = loop_ff;
  assign feedback_tick = loop_if.pulse;
  assign oscillator_bias = bias_ff[BIAS_HI:0];
  assign lane_preemphasis = lanes_ff;
  assign aux_output_enable = aux_en;
  assign aux_clock_output = aux_out_ff;

  // Outputs lag one edge, so the edge after reset release is left out
  chk_ref_gate: assert property (@(posedge clock)
    disable iff (!nrst) $past(nrst) |->
      synth_ref_output == ($past(ref_ctrl_ff[REF_EN_BIT]) && $past(pll_on)))
    else $error("reference output gate wrong");
  chk_ref_default: assert property (@(posedge clock)
    $past(!nrst) && nrst |-> ref_ctrl_ff[REF_EN_BIT])
    else $error("reference enable not set after reset");
  chk_post_apply: assert property (@(posedge clock)
    disable iff (!nrst) $past(nrst) && $fell(synth_pll_reset) |=>
      post_ratio == pdc_post_ratio($past(fbdiv1_ff[POST_HI:POST_LO])))
    else $error("post ratio not applied");
  chk_pre_apply: assert property (@(posedge clock)
    disable iff (!nrst) $past(nrst) && $fell(synth_pll_reset) |=>
      prescale_ratio == pdc_pre_ratio($past(fbdiv1_ff[PRE_HI:PRE_LO])))
    else $error("prescale ratio not applied");
  chk_loop_one: assert property (@(posedge clock)
    disable iff (!nrst)
      loop_ratio == 6'h01 && sample_tick && !loop_if.clear |=> feedback_tick)
    else $error("divide by one missed a pulse");
  chk_loop_clear: assert property (@(posedge clock)
    disable iff (!nrst) loop_if.clear |=> !feedback_tick)
    else $error("feedback pulse while cleared");
  chk_loop_default: assert property (@(posedge clock)
    $past(!nrst) && nrst |-> loop_ratio == RST_FBDIV2[LOOP_HI:0])
    else $error("loop ratio reset value wrong");
  chk_lane_common: assert property (@(posedge clock)
    disable iff (!nrst) $past(nrst) |->
      lane_preemphasis == {LANES{$past(pe_ff[PE_HI:0])}})
    else $error("lanes differ from common setting");
  chk_aux_off: assert property (@(posedge clock)
    disable iff (!nrst) !aux_en |=> !aux_clock_output)
    else $error("aux output active while disabled");
  chk_aux_tstamp: assert property (@(posedge clock)
    disable iff (!nrst)
      aux_en && aux_mode == MODE_TSTAMP |=> aux_clock_output == $past(ts_ff))
    else $error("timestamp not passed to aux output");
  chk_aux_reinit: assert property (@(posedge clock)
    disable iff (!nrst)
      (ser_reinit && aux_en && aux_clk_mode) [*2] |=> !aux_clock_output)
    else $error("aux clock not stopped by reinit");
  chk_ovr_off: assert property (@(posedge clock)
    disable iff (!nrst)
      override_active && !override_pll_on_value |=> !synth_ref_output)
    else $error("override off did not stop reference output");
  chk_apply_hold: assert property (@(posedge clock)
    disable iff (!nrst)
      synth_pll_reset |=> $stable(loop_ratio) && $stable(post_ratio))
    else $error("ratio changed while PLL reset held");
endmodule : pdc_top

//--- inc/pdc_div_if.sv
`timescale 1ns/10ps
interface pdc_div_if #(parameter int W = 6);
  logic clear;
  logic tick;
  logic [W-1:0] ratio;
  logic pulse;
  logic level;
  modport div (input clear, input tick, input ratio, output pulse,
               output level);
  modport ctl (output clear, output tick, output ratio, input pulse,
               input level);
endinterface : pdc_div_if

//--- inc/pdc_pkg.sv
package pdc_pkg;
  // Register addresses on the serial control port
  localparam logic [14:0] ADR_REF_CTRL = 15'h003C;
  localparam logic [14:0] ADR_FBDIV1 = 15'h003D;
  localparam logic [14:0] ADR_FBDIV2 = 15'h003E;
  localparam logic [14:0] ADR_BIAS = 15'h003F;
  localparam logic [14:0] ADR_PE = 15'h0048;
  localparam logic [14:0] ADR_AUX = 15'h0057;
  // Reset values
  localparam logic [7:0] RST_REF_CTRL = 8'h01;
  localparam logic [7:0] RST_FBDIV1 = 8'h00;
  localparam logic [7:0] RST_FBDIV2 = 8'h20;
  localparam logic [7:0] RST_BIAS = 8'h4F;
  localparam logic [7:0] RST_PE = 8'h00;
  localparam logic [7:0] RST_AUX = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Field positions
  localparam int REF_EN_BIT = 0;
  localparam int POST_HI = 3;
  localparam int POST_LO = 2;
  localparam int PRE_HI = 1;
  localparam int PRE_LO = 0;
  localparam int LOOP_HI = 5;
  localparam int BIAS_HI = 6;
  localparam int PE_HI = 3;
  localparam int AUX_EN_BIT = 7;
  localparam int AUX_MODE_HI = 2;
  // Auxiliary output modes
  localparam logic [2:0] MODE_UI16 = 3'h0;
  localparam logic [2:0] MODE_UI32 = 3'h1;
  localparam logic [2:0] MODE_UI64 = 3'h2;
  localparam logic [2:0] MODE_TSTAMP = 3'h3;
  // Half periods of the auxiliary clocks, in unit intervals
  localparam logic [5:0] HALF_UI16 = 6'h08;
  localparam logic [5:0] HALF_UI32 = 6'h10;
  localparam logic [5:0] HALF_UI64 = 6'h20;
  // Divide ratios
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] RATIO_1 = 3'h1;
  localparam logic [2:0] RATIO_2 = 3'h2;
  localparam logic [2:0] RATIO_3 = 3'h3;
  localparam logic [2:0] RATIO_4 = 3'h4;
  localparam logic [2:0] RATIO_5 = 3'h5;
  localparam logic [1:0] CODE_0 = 2'h0;
  localparam logic [1:0] CODE_1 = 2'h1;
  localparam logic [1:0] CODE_2 = 2'h2;
  // Serial frame: one read flag, 15 address bits, 8 data bits
  localparam logic [4:0] SPI_HEAD_BITS = 5'h10;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;
  localparam int SPI_RW_BIT = 15;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HEAD = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } pdc_spi_state_t;

  function automatic logic [2:0] pdc_pre_ratio(input logic [1:0] code);
    if (code == CODE_0) begin
      return RATIO_5;
    end else if (code == CODE_1) begin
      return RATIO_4;
    end else if (code == CODE_2) begin
      return RATIO_3;
    end
    return RATIO_NONE;
  endfunction : pdc_pre_ratio

  function automatic logic [2:0] pdc_post_ratio(input logic [1:0] code);
    if (code == CODE_0) begin
      return RATIO_1;
    end else if (code == CODE_1) begin
      return RATIO_2;
    end else if (code == CODE_2) begin
      return RATIO_4;
    end
    return RATIO_NONE;
  endfunction : pdc_post_ratio

  function automatic logic [5:0] pdc_aux_half(input logic [2:0] mode);
    if (mode == MODE_UI16) begin
      return HALF_UI16;
    end else if (mode == MODE_UI32) begin
      return HALF_UI32;
    end
    return HALF_UI64;
  endfunction : pdc_aux_half
endpackage : pdc_pkg

//--- verification/pdc_top_tb.sv
`timescale 1ns/10ps
module pdc_top_tb;
  import pdc_pkg::*;
  logic clock, nrst, spi_csb_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic pll_enable_pin, override_active, override_pll_on_value;
  logic synth_pll_reset, sample_tick, ui_tick, ser_reinit, timestamp_input;
  logic pll_on, synth_ref_output, feedback_tick, aux_output_enable;
  logic aux_clock_output, aux_prev;
  logic [2:0] prescale_ratio, post_ratio;
  logic [5:0] loop_ratio;
  logic [6:0] oscillator_bias;
  logic [31:0] lane_preemphasis, seed;
  logic [7:0] q;
  int n_mismatch, comparisons, cycles, st_cnt, fb_len, ui_cnt, aux_len;
  int pre_m[4] = '{5, 4, 3, 0};
  int post_m[4] = '{1, 2, 4, 0};
  int half_m[3] = '{8, 16, 32};
  int pre_x, post_x, n;
  logic e, ts, oe_seen;
  logic [2:0] aux_cur;

  pdc_top #(.LANES(8), .PE_W(4)) pdc_top_inst (
    .clock(clock), .nrst(nrst), .spi_csb_n(spi_csb_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .pll_enable_pin(pll_enable_pin),
    .override_active(override_active),
    .override_pll_on_value(override_pll_on_value),
    .synth_pll_reset(synth_pll_reset), .sample_tick(sample_tick),
    .ui_tick(ui_tick), .ser_reinit(ser_reinit),
    .timestamp_input(timestamp_input), .pll_on(pll_on),
    .synth_ref_output(synth_ref_output), .prescale_ratio(prescale_ratio),
    .post_ratio(post_ratio), .loop_ratio(loop_ratio),
    .feedback_tick(feedback_tick), .oscillator_bias(oscillator_bias),
    .lane_preemphasis(lane_preemphasis),
    .aux_output_enable(aux_output_enable),
    .aux_clock_output(aux_clock_output)
  );

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // Strobes every other cycle, so intervals are counted in ticks
  always @(posedge clock) begin
    sample_tick <= ~sample_tick & nrst;
    ui_tick <= ~ui_tick & nrst;
  end

  // Design outputs are read before this edge's updates land
  always @(posedge clock) begin
    if (sample_tick === 1'h1) st_cnt++;
    if (feedback_tick === 1'h1) begin
      fb_len = st_cnt;
      st_cnt = 0;
    end
    if (ui_tick === 1'h1) ui_cnt++;
    if (aux_clock_output !== aux_prev) begin
      aux_len = ui_cnt;
      ui_cnt = 0;
    end
    aux_prev = aux_clock_output;
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Slow edges: both sclk phases span several clocks for the edge detector
  task automatic spi(input logic rd, input logic [14:0] a,
                     input logic [7:0] d);
    logic [23:0] f;
    f = {rd, a, d};
    @(posedge clock);
    spi_csb_n <= 1'h0;
    cyc(2);
    for (int i = 0; i < 24; i++) begin
      spi_sclk <= 1'h0;
      spi_sdi <= f[23-i];
      cyc(4);
      if (i >= 16) q[23-i] = spi_sdo;
      if (i == 20) oe_seen = spi_sdo_oe;
      spi_sclk <= 1'h1;
      cyc(3);
    end
    spi_sclk <= 1'h0;
    cyc(3);
    spi_csb_n <= 1'h1;
    cyc(3);
  endtask : spi

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'h0, a, d);
    chk(oe_seen, 1'h0);
  endtask : wr

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] x);
    spi(1'h1, a, 8'h00);
    chk({24'h000000, q}, {24'h000000, x});
    chk(oe_seen, 1'h1);
  endtask : rd_chk

  // Mode moves only while the enable is clear, then the enable is set
  task automatic aux_set(input logic [2:0] m);
    wr(ADR_AUX, {5'h00, aux_cur});
    wr(ADR_AUX, {5'h00, m});
    wr(ADR_AUX, {5'h10, m});
    aux_cur = m;
  endtask : aux_set

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    {nrst, spi_sclk, spi_sdi, sample_tick, ui_tick, ser_reinit} = 6'h00;
    {override_active, override_pll_on_value, synth_pll_reset} = 3'h0;
    {timestamp_input, aux_prev, aux_cur} = 5'h00;
    spi_csb_n = 1'h1;
    pll_enable_pin = 1'h1;
    seed = 32'h00000048;
    cyc(12);
    nrst <= 1'h1;
    cyc(2);
    @(negedge clock);
    chk(prescale_ratio, 5);
    chk(post_ratio, 1);
    chk(loop_ratio, 32);
    chk(synth_ref_output, 1);
    rd_chk(ADR_REF_CTRL, 8'h01);
    rd_chk(ADR_FBDIV2, 8'h20);
    rd_chk(ADR_FBDIV1, 8'h00);
    rd_chk(ADR_BIAS, 8'h4F);
    rd_chk(15'h0040, 8'h00);
    $display("test reset done");
    for (int en = 1; en >= 0; en--) begin
      wr(ADR_REF_CTRL, {7'h00, en[0]});
      for (int j = 0; j < 8; j++) begin
        @(posedge clock);
        {override_active, override_pll_on_value, pll_enable_pin} <= j[2:0];
        cyc(2);
        @(negedge clock);
        e = j[2] ? j[1] : j[0];
        chk(pll_on, e);
        chk(synth_ref_output, e & en[0]);
      end
    end
    @(posedge clock);
    {override_active, pll_enable_pin} <= 2'h1;
    $display("test reference output done");
    {pre_x, post_x} = {5, 1};
    for (int c = 3; c >= 0; c--) begin
      @(posedge clock);
      synth_pll_reset <= 1'h1;
      wr(ADR_FBDIV1, {4'h0, c[1:0], c[1:0]});
      chk(prescale_ratio, pre_x);
      synth_pll_reset <= 1'h0;
      cyc(3);
      @(negedge clock);
      {pre_x, post_x} = {pre_m[c], post_m[c]};
      chk(prescale_ratio, pre_x);
      chk(post_ratio, post_x);
    end
    $display("test prescale and post done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      seed = xs(seed);
      n = (k == 0) ? 1 : (k == 1) ? 63 : 2 + seed % 61;
      synth_pll_reset <= 1'h1;
      wr(ADR_FBDIV2, {2'h0, n[5:0]});
      synth_pll_reset <= 1'h0;
      cyc(6 * n + 12);
      chk(loop_ratio, n);
      chk(fb_len, n);
    end
    $display("test loop divider done");
    wr(ADR_BIAS, 8'h4A);
    chk(oscillator_bias, 7'h4A);
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      wr(ADR_PE, {4'h0, seed[3:0]});
      chk(lane_preemphasis, {8{seed[3:0]}});
    end
    $display("test bias and emphasis done");
    for (int m = 0; m < 3; m++) begin
      aux_set(m[2:0]);
      chk(aux_output_enable, 1);
      cyc(8 * half_m[m] + 20);
      chk(aux_len, half_m[m]);
    end
    // Mode 2 toggles every 64 clocks, so a held reinit must show flat zero
    ser_reinit <= 1'h1;
    cyc(4);
    chk(aux_clock_output, 0);
    cyc(100);
    chk(aux_clock_output, 0);
    ser_reinit <= 1'h0;
    aux_set(3'h3);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      ts = seed[0];
      timestamp_input <= ts;
      cyc(4);
      chk(aux_clock_output, ts);
    end
    for (int m = 4; m < 8; m++) begin
      aux_set(m[2:0]);
      cyc(40);
      chk(aux_clock_output, 0);
    end
    rd_chk(ADR_AUX, 8'h87);
    wr(ADR_AUX, 8'h07);
    wr(ADR_AUX, 8'h03);
    timestamp_input <= 1'h1;
    cyc(4);
    chk(aux_output_enable, 0);
    chk(aux_clock_output, 0);
    $display("test auxiliary output done");
    final_report();
  end
endmodule : pdc_top_tb
